/* verilog/htc_cfg.svh */
// Register map, field positions and reset values of the hard timer/counter
`ifndef HTC_CFG_SVH
`define HTC_CFG_SVH

// Word-aligned byte offsets on the Wishbone slave
`define HTC_OFS_CTRL      8'h00
`define HTC_OFS_PRESCALE  8'h04
`define HTC_OFS_TOP       8'h08
`define HTC_OFS_COMPARE   8'h0c
`define HTC_OFS_COUNT     8'h10
`define HTC_OFS_CAPTURE   8'h14
`define HTC_OFS_IRQ_STAT  8'h18
`define HTC_OFS_IRQ_MASK  8'h1c
`define HTC_OFS_WAKE_MASK 8'h20

// Widths
`define HTC_ADR_W         8
`define HTC_DAT_W         32
`define HTC_IRQ_W         3

// Interrupt bit positions in status, mask and wake mask
`define HTC_IRQ_OVF       0
`define HTC_IRQ_MATCH     1
`define HTC_IRQ_CAP       2

// Reset values
`define HTC_CTRL_RST      8'h10
`define HTC_PRESCALE_RST  16'h0000
`define HTC_TOP_RST       16'hffff
`define HTC_COMPARE_RST   16'h8000
`define HTC_IRQ_RST       3'h0

`endif

/* verilog/htc_pkg.sv */
// Types shared by the hard timer/counter design
package htc_pkg;

    // Operating modes, in control register order
    typedef enum logic [1:0] {
        htc_mode_watchdog,
        htc_mode_ctc,
        htc_mode_fast_pwm,
        htc_mode_pfc_pwm
    } htc_mode_t;

    // Count direction of the phase-and-frequency-correct sweep
    typedef enum logic {
        htc_dir_up,
        htc_dir_down
    } htc_dir_t;

    // Control register layout, most significant field first
    typedef struct packed {
        logic      out_invert;
        logic      count_down;
        logic      enable;
        logic      reset_pin_enable;
        logic      capture_enable;
        logic      clock_from_pin;
        htc_mode_t mode;
    } htc_ctrl_t;

    // One Wishbone request as seen by the slave
    typedef struct packed {
        logic [7:0]  adr;
        logic [31:0] dat;
        logic [3:0]  sel;
        logic        we;
        logic        valid;
    } htc_wb_req_t;

endpackage : htc_pkg

/* verilog/htc_timer_counter.sv */
// 16-bit up/down timer/counter with compare, PWM, capture and Wishbone registers
// Functional notes
// - Sixteen-bit counter counts up or down; compare unit acts on its own.
// - Modes: watchdog, clear on compare match, fast PWM, phase/frequency-correct PWM.
// - Compare output makes waveforms; PWM stays glitch-free when period changes.
// - Counting clock has a selectable source and a programmable prescaler.
// - Capture in non-PWM bus mode: synchronise trigger, find rising edge, stamp count.
// - Three interrupt sources: overflow, compare match, input capture.
// - Interrupt output is plain overflow flag standalone, else governed by IRQ registers.
// - One static interrupt output plus a separate wake-up interrupt.
// - Counter reloads by itself at each period end.
// - Standalone mode runs preloaded settings; reset pin stays enabled.
// - Control and status registers sit on a Wishbone slave port.
//
// Design decisions made here: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`include "htc_cfg.svh"

module htc_timer_counter
    import htc_pkg::*;
#(
    parameter int                 CW           = 16,
    parameter int                 PW           = 16,
    parameter logic [7:0]         PRE_CTRL     = 8'h26,
    parameter logic [PW-1:0]      PRE_PRESCALE = 16'h0000,
    parameter logic [CW-1:0]      PRE_TOP      = 16'hffff,
    parameter logic [CW-1:0]      PRE_COMPARE  = 16'h8000
) (
    input  wire logic             clock,
    input  wire logic             srst,
    input  wire logic [7:0]       wb_adr_i,
    input  wire logic [31:0]      wb_dat_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic             wb_we_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_cyc_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    input  wire logic             standalone_mode,
    input  wire logic             counter_clock_in,
    input  wire logic             counter_reset_n,
    input  wire logic             capture_trigger_in,
    output logic                  counter_irq_out,
    output logic                  wakeup_irq_out,
    output logic                  compare_wave_out,
    output logic      [CW-1:0]    running_count_value
);

    // Merge write data into a register through the byte enables
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  sel);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction : merge_bytes

    // Pad a narrow register value to the bus width
    function automatic logic [31:0] widen16(input logic [15:0] v);
        return {16'h0000, v};
    endfunction : widen16

    // Registers
    htc_ctrl_t          ctrl_reg;
    logic [PW-1:0]      prescale_reg;
    logic [CW-1:0]      top_reg;
    logic [CW-1:0]      compare_reg;
    logic [CW-1:0]      top_act_reg;
    logic [CW-1:0]      compare_act_reg;
    logic [CW-1:0]      count_reg;
    logic [PW-1:0]      pre_cnt_reg;
    htc_dir_t           dir_reg;
    logic [CW-1:0]      capture_value_reg;
    logic [2:0]         irq_status_reg;
    logic [2:0]         irq_mask_reg;
    logic [2:0]         wake_mask_reg;
    logic               wave_reg;
    logic               ack_reg;
    logic [31:0]        dat_reg;

    // Synchroniser stages for the pins
    logic               sa_s1_reg;
    logic               sa_s2_reg;
    logic               cki_s1_reg;
    logic               cki_s2_reg;
    logic               cki_s3_reg;
    logic               rstn_s1_reg;
    logic               rstn_s2_reg;
    logic               cap_s1_reg;
    logic               cap_s2_reg;
    logic               cap_s3_reg;

    // Combinational terms
    htc_wb_req_t        req;
    htc_ctrl_t          ctrl_eff;
    logic [PW-1:0]      prescale_eff;
    logic [CW-1:0]      top_eff;
    logic [CW-1:0]      compare_eff;
    logic               pin_clear;
    logic               cnt_clear;
    logic               src_tick;
    logic               tick;
    logic               step;
    logic               is_pwm;
    logic               at_top;
    logic               at_bottom;
    logic               period_end;
    logic               ovf_evt;
    logic               match_evt;
    logic               cap_evt;
    logic [2:0]         irq_set;
    logic [2:0]         irq_clr;
    logic               wr_count;
    logic [31:0]        rd_data;
    logic [CW-1:0]      count_next;
    htc_dir_t           dir_next;

    // Pin synchronisers, two flops before any logic
    always_ff @(posedge clock) begin
        sa_s1_reg   <= standalone_mode;
        sa_s2_reg   <= sa_s1_reg;
        cki_s1_reg  <= counter_clock_in;
        cki_s2_reg  <= cki_s1_reg;
        cki_s3_reg  <= cki_s2_reg;
        rstn_s1_reg <= counter_reset_n;
        rstn_s2_reg <= rstn_s1_reg;
        cap_s1_reg  <= capture_trigger_in;
        cap_s2_reg  <= cap_s1_reg;
        cap_s3_reg  <= cap_s2_reg;
    end

    // Standalone runs from preloads with the reset pin forced on
    always_comb begin
        ctrl_eff     = ctrl_reg;
        prescale_eff = prescale_reg;
        top_eff      = top_reg;
        compare_eff  = compare_reg;
        if (sa_s2_reg) begin
            ctrl_eff                  = htc_ctrl_t'(PRE_CTRL);
            ctrl_eff.reset_pin_enable = 1'b1;
            prescale_eff              = PRE_PRESCALE;
            top_eff                   = PRE_TOP;
            compare_eff               = PRE_COMPARE;
        end
    end

    // Pin reset clears counter state while low and enabled
    assign pin_clear = ctrl_eff.reset_pin_enable & ~rstn_s2_reg;
    assign cnt_clear = srst | pin_clear;

    // Bus request, taken once per cycle until ack
    assign req.adr   = wb_adr_i;
    assign req.dat   = wb_dat_i;
    assign req.sel   = wb_sel_i;
    assign req.we    = wb_we_i;
    assign req.valid = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign wr_count  = req.valid & req.we & ~sa_s2_reg & (req.adr == `HTC_OFS_COUNT);

    // Counting clock source and prescaler
    assign src_tick = ctrl_eff.clock_from_pin ? (cki_s2_reg & ~cki_s3_reg) : 1'b1;
    assign tick     = src_tick & (pre_cnt_reg == prescale_eff);
    assign step     = tick & ctrl_eff.enable;

    always_ff @(posedge clock) begin
        if (cnt_clear || !ctrl_eff.enable) begin
            pre_cnt_reg <= '0;
        end else if (src_tick) begin
            pre_cnt_reg <= (pre_cnt_reg == prescale_eff) ? '0 : pre_cnt_reg + 1'b1;
        end
    end

    // Period decode
    assign is_pwm    = (ctrl_eff.mode == htc_mode_fast_pwm) || (ctrl_eff.mode == htc_mode_pfc_pwm);
    assign at_top    = (count_reg >= top_act_reg);
    assign at_bottom = (count_reg == '0);

    // Next count per mode, with automatic reload
    always_comb begin
        count_next = count_reg;
        dir_next   = dir_reg;
        period_end = 1'b0;
        case (ctrl_eff.mode)
            htc_mode_watchdog: begin
                count_next = ctrl_eff.count_down ? count_reg - 1'b1 : count_reg + 1'b1;
                period_end = ctrl_eff.count_down ? at_bottom : (count_reg == {CW{1'b1}});
            end
            htc_mode_ctc, htc_mode_fast_pwm: begin
                if (!ctrl_eff.count_down || ctrl_eff.mode == htc_mode_fast_pwm) begin
                    count_next = at_top ? '0 : count_reg + 1'b1;
                    period_end = at_top;
                end else begin
                    count_next = at_bottom ? top_act_reg : count_reg - 1'b1;
                    period_end = at_bottom;
                end
            end
            default: begin
                if (top_act_reg == '0) begin
                    count_next = '0;
                    period_end = 1'b1;
                end else if (dir_reg == htc_dir_up) begin
                    if (at_top) begin
                        dir_next   = htc_dir_down;
                        count_next = top_act_reg - 1'b1;
                    end else begin
                        count_next = count_reg + 1'b1;
                    end
                end else if (at_bottom) begin
                    dir_next   = htc_dir_up;
                    count_next = count_reg + 1'b1;
                    period_end = 1'b1;
                end else begin
                    count_next = count_reg - 1'b1;
                end
            end
        endcase
    end

    // Counter register
    always_ff @(posedge clock) begin
        if (cnt_clear) begin
            count_reg <= '0;
            dir_reg   <= htc_dir_up;
        end else if (wr_count) begin
            count_reg <= CW'(merge_bytes(widen16(count_reg), req.dat, req.sel));
        end else if (step) begin
            count_reg <= count_next;
            dir_reg   <= dir_next;
        end
    end

    // Active period and compare; enabled PWM modes only take new values at a period end or a clear
    always_ff @(posedge clock) begin
        if (cnt_clear) begin
            top_act_reg     <= top_eff;
            compare_act_reg <= compare_eff;
        end else if (!is_pwm || !ctrl_eff.enable || (step && period_end)) begin
            top_act_reg     <= top_eff;
            compare_act_reg <= compare_eff;
        end
    end

    // Events
    assign ovf_evt   = step & period_end;
    assign match_evt = step & (count_reg == compare_act_reg);
    assign cap_evt   = cap_s2_reg & ~cap_s3_reg & ctrl_eff.capture_enable & ~is_pwm & ~sa_s2_reg;

    // Compare output waveform
    always_ff @(posedge clock) begin
        if (cnt_clear) begin
            wave_reg <= srst ? 1'b0 : ctrl_eff.out_invert;   // Known level before the control register settles
        end else begin
            case (ctrl_eff.mode)
                htc_mode_watchdog: begin
                    if (ovf_evt) begin
                        wave_reg <= ~wave_reg;
                    end
                end
                htc_mode_ctc: begin
                    if (match_evt) begin
                        wave_reg <= ~wave_reg;
                    end
                end
                default: begin
                    wave_reg <= (count_reg < compare_act_reg) ^ ctrl_eff.out_invert;
                end
            endcase
        end
    end

    // Capture time stamp
    always_ff @(posedge clock) begin
        if (cnt_clear) begin
            capture_value_reg <= '0;
        end else if (cap_evt) begin
            capture_value_reg <= count_reg;
        end
    end

    // Sticky interrupt status; a new event wins over a read clear
    assign irq_set[`HTC_IRQ_OVF]   = ovf_evt;
    assign irq_set[`HTC_IRQ_MATCH] = match_evt;
    assign irq_set[`HTC_IRQ_CAP]   = cap_evt;
    assign irq_clr = (req.valid && !req.we && req.adr == `HTC_OFS_IRQ_STAT) ? '1 : '0;

    always_ff @(posedge clock) begin
        if (cnt_clear) begin
            irq_status_reg <= `HTC_IRQ_RST;
        end else begin
            irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
        end
    end

    // Control registers written by the bus
    always_ff @(posedge clock) begin
        if (srst) begin
            ctrl_reg      <= htc_ctrl_t'(`HTC_CTRL_RST);
            prescale_reg  <= `HTC_PRESCALE_RST;
            top_reg       <= `HTC_TOP_RST;
            compare_reg   <= `HTC_COMPARE_RST;
            irq_mask_reg  <= `HTC_IRQ_RST;
            wake_mask_reg <= `HTC_IRQ_RST;
        end else if (req.valid && req.we) begin
            if (req.adr == `HTC_OFS_CTRL) begin
                ctrl_reg <= htc_ctrl_t'(8'(merge_bytes({24'h000000, ctrl_reg}, req.dat, req.sel)));
            end else if (req.adr == `HTC_OFS_PRESCALE) begin
                prescale_reg <= PW'(merge_bytes(widen16(prescale_reg), req.dat, req.sel));
            end else if (req.adr == `HTC_OFS_TOP) begin
                top_reg <= CW'(merge_bytes(widen16(top_reg), req.dat, req.sel));
            end else if (req.adr == `HTC_OFS_COMPARE) begin
                compare_reg <= CW'(merge_bytes(widen16(compare_reg), req.dat, req.sel));
            end else if (req.adr == `HTC_OFS_IRQ_MASK) begin
                irq_mask_reg <= 3'(merge_bytes({29'h0, irq_mask_reg}, req.dat, req.sel));
            end else if (req.adr == `HTC_OFS_WAKE_MASK) begin
                wake_mask_reg <= 3'(merge_bytes({29'h0, wake_mask_reg}, req.dat, req.sel));
            end
        end
    end

    // Read data mux; unmapped addresses read zero
    always_comb begin
        if (req.adr == `HTC_OFS_CTRL) begin
            rd_data = {24'h000000, ctrl_eff};
        end else if (req.adr == `HTC_OFS_PRESCALE) begin
            rd_data = widen16(prescale_eff);
        end else if (req.adr == `HTC_OFS_TOP) begin
            rd_data = widen16(top_eff);
        end else if (req.adr == `HTC_OFS_COMPARE) begin
            rd_data = widen16(compare_eff);
        end else if (req.adr == `HTC_OFS_COUNT) begin
            rd_data = widen16(count_reg);
        end else if (req.adr == `HTC_OFS_CAPTURE) begin
            rd_data = widen16(capture_value_reg);
        end else if (req.adr == `HTC_OFS_IRQ_STAT) begin
            rd_data = {29'h0, irq_status_reg};
        end else if (req.adr == `HTC_OFS_IRQ_MASK) begin
            rd_data = {29'h0, irq_mask_reg};
        end else if (req.adr == `HTC_OFS_WAKE_MASK) begin
            rd_data = {29'h0, wake_mask_reg};
        end else begin
            rd_data = '0;
        end
    end

    // Registered acknowledge and read data, one cycle after the request
    always_ff @(posedge clock) begin
        if (srst) begin
            ack_reg <= 1'b0;
            dat_reg <= '0;
        end else begin
            ack_reg <= req.valid;
            if (req.valid && !req.we) begin
                dat_reg <= rd_data;
            end
        end
    end

    // Outputs
    assign wb_ack_o            = ack_reg;
    assign wb_dat_o            = dat_reg;
    assign compare_wave_out    = wave_reg;
    assign running_count_value = count_reg;
    assign counter_irq_out     = sa_s2_reg ? irq_status_reg[`HTC_IRQ_OVF]
                                           : |(irq_status_reg & irq_mask_reg);
    assign wakeup_irq_out      = |(irq_status_reg & wake_mask_reg);

endmodule : htc_timer_counter

/* test/htc_props.sv */
// Port checks on the hard timer/counter
`timescale 1ns/1ps
module htc_props #(
    parameter int CW = 16
) (
    input wire logic          clock,
    input wire logic          srst,
    input wire logic          wb_we_i,
    input wire logic          wb_stb_i,
    input wire logic          wb_cyc_i,
    input wire logic [31:0]   wb_dat_o,
    input wire logic          wb_ack_o,
    input wire logic          counter_reset_n,
    input wire logic          counter_irq_out,
    input wire logic          wakeup_irq_out,
    input wire logic          compare_wave_out,
    input wire logic [CW-1:0] running_count_value
);
    // Single domain, paused in bus reset
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    // Ack one cycle after the request, one cycle long
    a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_upper_half_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0)
        else $error("upper data not zero");

    // Count steps by one, reloads or is written
    a_count_single_step: assert property (
        !$past(wb_cyc_i && wb_stb_i && wb_we_i) && running_count_value != $past(running_count_value)
        |-> running_count_value == $past(running_count_value) + 1'b1
         || running_count_value == $past(running_count_value) - 1'b1
         || running_count_value == '0 || $past(running_count_value) == '0)
        else $error("count jumped");

    // Pin reset clears count and flags
    a_pin_clears_count: assert property (!counter_reset_n [*4] |-> running_count_value == '0)
        else $error("pin reset kept count");
    a_pin_clears_irq: assert property (!counter_reset_n [*5] |-> !counter_irq_out && !wakeup_irq_out)
        else $error("pin reset kept irq");

    // Bus reset leaves every output quiet
    a_reset_quiet: assert property (disable iff (1'b0) srst |=> !wb_ack_o && wb_dat_o == 32'h0
        && running_count_value == '0 && !counter_irq_out && !wakeup_irq_out && !compare_wave_out)
        else $error("outputs not reset");

    // Main scenarios reached
    c_read_ack: cover property (wb_ack_o && !wb_we_i);
    c_irq_rise: cover property ($rose(counter_irq_out));
    c_wake_rise: cover property ($rose(wakeup_irq_out));
    c_pin_reset: cover property (!counter_reset_n [*4]);
endmodule : htc_props

/* test/htc_wb_master.sv */
// Bus master model for the timer/counter registers
`timescale 1ns/1ps
module htc_wb_master (
    input  wire logic        clock,
    input  wire logic        ack_i,
    input  wire logic [31:0] dat_i,
    output logic      [7:0]  adr_o,
    output logic      [31:0] dat_o,
    output logic      [3:0]  sel_o,
    output logic             we_o,
    output logic             stb_o,
    output logic             cyc_o
);
    int n_timeout = 0;

    // Idle bus at time zero
    initial begin
        {adr_o, dat_o, sel_o, we_o, stb_o, cyc_o} = '0;
    end

    // Classic cycle: hold until ack is sampled, then release
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wdat,
                        output logic [31:0] rdat);
        @(posedge clock);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= we;
        adr_o <= adr;
        dat_o <= wdat;
        sel_o <= 4'hf;
        for (int k = 0; k < 16; k++) begin
            @(posedge clock);
            if (ack_i === 1'b1) break;
        end
        if (ack_i !== 1'b1) n_timeout++;
        rdat = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        dat_o <= ~wdat; // Released data shows the inverse
    endtask : xfer
endmodule : htc_wb_master

/* test/htc_timer_counter_tb_top.sv */
// Self-checking bench for the hard timer/counter
`timescale 1ns/1ps
`include "htc_cfg.svh"
module htc_timer_counter_tb_top;
    logic        clock = 1'b0;
    logic        srst = 1'b1;
    logic        standalone_mode = 1'b0;
    logic        counter_clock_in = 1'b0;
    logic        counter_reset_n = 1'b1;
    logic        capture_trigger_in = 1'b0;
    logic [7:0]  wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [3:0]  wb_sel_i;
    logic        wb_we_i, wb_stb_i, wb_cyc_i, wb_ack_o;
    logic        counter_irq_out, wakeup_irq_out, compare_wave_out;
    logic [15:0] running_count_value;
    int          n_mismatch = 0;
    int          n_checks = 0;
    localparam logic [7:0] RA [10] = '{`HTC_OFS_CTRL, `HTC_OFS_PRESCALE, `HTC_OFS_TOP, `HTC_OFS_COMPARE,
        `HTC_OFS_COUNT, `HTC_OFS_CAPTURE, `HTC_OFS_IRQ_STAT, `HTC_OFS_IRQ_MASK, `HTC_OFS_WAKE_MASK, 8'h24};
    localparam logic [31:0] RV [10] = '{32'h10, 32'h0, 32'hffff, 32'h8000, 32'h0, 32'h0, 32'h0, 32'h0,
        32'h0, 32'h0};

    // 50 MHz system clock
    always #10 clock = ~clock;

    htc_timer_counter #(.PRE_CTRL(8'h35), .PRE_TOP(16'h0003), .PRE_COMPARE(16'h0002)) i_dut (
        .clock, .srst, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_stb_i, .wb_cyc_i, .wb_dat_o, .wb_ack_o,
        .standalone_mode, .counter_clock_in, .counter_reset_n, .capture_trigger_in, .counter_irq_out,
        .wakeup_irq_out, .compare_wave_out, .running_count_value);

    htc_wb_master i_master (.clock(clock), .ack_i(wb_ack_o), .dat_i(wb_dat_o), .adr_o(wb_adr_i),
        .dat_o(wb_dat_i), .sel_o(wb_sel_i), .we_o(wb_we_i), .stb_o(wb_stb_i), .cyc_o(wb_cyc_i));

    // Verdict and end of run
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    // Compare words and flags
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected value at %0t: %h, want %h", $time, got, exp);
        end
    endtask : chk_val
    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected flag at %0t: %b, want %b", $time, got, exp);
        end
    endtask : chk_bit

    // Bus access; a hung bus ends the run
    task automatic acc(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        i_master.xfer(we, a, d, r);
        if (i_master.n_timeout != 0) begin
            n_mismatch++;
            $display("unexpected bus hang at %0t", $time);
            report_and_stop();
        end
    endtask : acc
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        acc(1'b1, a, d, r);
    endtask : wr
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick
    task automatic duty(output int hi);
        hi = 0;
        repeat (100) begin
            tick(1);
            hi += int'(compare_wave_out === 1'b1);
        end
    endtask : duty

    // Main sequence
    initial begin
        logic [31:0] v;
        logic [15:0] c0, mx;
        int          i, hi;
        logic        dn;
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        wr(8'h24, 32'h5a5a);
        wr(`HTC_OFS_CAPTURE, 32'h1234);
        for (i = 0; i < 10; i++) begin
            acc(1'b0, RA[i], 32'h0, v);
            chk_val(v, RV[i]);
        end
        // Overflow up and down, masked and unmasked
        for (i = 0; i < 2; i++) begin
            wr(`HTC_OFS_CTRL, 32'h10);
            wr(`HTC_OFS_IRQ_MASK, 32'h0);
            wr(`HTC_OFS_WAKE_MASK, 32'h0);
            wr(`HTC_OFS_COUNT, (i == 1) ? 32'h2 : 32'hfffd);
            acc(1'b0, `HTC_OFS_IRQ_STAT, 32'h0, v);
            wr(`HTC_OFS_CTRL, (i == 1) ? 32'h70 : 32'h30);
            tick(8);
            chk_bit(counter_irq_out, 1'b0);
            wr(`HTC_OFS_IRQ_MASK, 32'h1);
            wr(`HTC_OFS_WAKE_MASK, 32'h1);
            tick(1);
            chk_bit(counter_irq_out, 1'b1);
            chk_bit(wakeup_irq_out, 1'b1);
            acc(1'b0, `HTC_OFS_IRQ_STAT, 32'h0, v);
            chk_val(v, 32'h1);
            tick(1);
            chk_bit(counter_irq_out, 1'b0);
        end
        // Prescaler divides by PRESCALE+1
        wr(`HTC_OFS_CTRL, 32'h10);
        wr(`HTC_OFS_PRESCALE, 32'h3);
        wr(`HTC_OFS_COUNT, 32'h0);
        wr(`HTC_OFS_CTRL, 32'h30);
        tick(4);
        c0 = running_count_value;
        tick(40);
        chk_val({16'h0, running_count_value - c0}, 32'd10);
        // Clear at TOP, match flag at compare
        wr(`HTC_OFS_CTRL, 32'h10);
        wr(`HTC_OFS_PRESCALE, 32'h0);
        wr(`HTC_OFS_TOP, 32'h4);
        wr(`HTC_OFS_COMPARE, 32'h2);
        wr(`HTC_OFS_COUNT, 32'h0);
        acc(1'b0, `HTC_OFS_IRQ_STAT, 32'h0, v);
        wr(`HTC_OFS_CTRL, 32'h31);
        mx = 16'h0;
        repeat (30) begin
            tick(1);
            if (running_count_value > mx) mx = running_count_value;
        end
        chk_val({16'h0, mx}, 32'h4);
        acc(1'b0, `HTC_OFS_IRQ_STAT, 32'h0, v);
        chk_val(v, 32'h3);
        // Fast PWM plain and inverted, then a period change at run time
        for (i = 0; i < 2; i++) begin
            wr(`HTC_OFS_CTRL, 32'h10);
            wr(`HTC_OFS_TOP, 32'h9);
            wr(`HTC_OFS_COMPARE, 32'h3);
            wr(`HTC_OFS_COUNT, 32'h0);
            wr(`HTC_OFS_CTRL, (i == 1) ? 32'hb2 : 32'h32);
            tick(20);
            duty(hi);
            chk_val(hi, (i == 1) ? 32'd70 : 32'd30);
        end
        wr(`HTC_OFS_TOP, 32'h4);
        tick(20);
        duty(hi);
        chk_val(hi, 32'd40);
        // Phase and frequency correct sweep
        wr(`HTC_OFS_CTRL, 32'h10);
        wr(`HTC_OFS_TOP, 32'h9);
        wr(`HTC_OFS_COUNT, 32'h0);
        acc(1'b0, `HTC_OFS_IRQ_STAT, 32'h0, v);
        wr(`HTC_OFS_CTRL, 32'h33);
        mx = 16'h0;
        dn = 1'b0;
        c0 = running_count_value;
        repeat (40) begin
            tick(1);
            if (running_count_value < c0) dn = 1'b1;
            if (running_count_value > mx) mx = running_count_value;
            c0 = running_count_value;
        end
        chk_bit(dn, 1'b1);
        chk_val({16'h0, mx}, 32'h9);
        acc(1'b0, `HTC_OFS_IRQ_STAT, 32'h0, v);
        chk_bit(v[`HTC_IRQ_OVF], 1'b1);
        // Capture stamps the count two steps after the trigger; the count also passes compare
        wr(`HTC_OFS_CTRL, 32'h10);
        wr(`HTC_OFS_COUNT, 32'h0);
        wr(`HTC_OFS_CTRL, 32'h38);
        acc(1'b0, `HTC_OFS_IRQ_STAT, 32'h0, v);
        @(posedge clock) capture_trigger_in <= 1'b1;
        #1 c0 = running_count_value;
        tick(8);
        acc(1'b0, `HTC_OFS_CAPTURE, 32'h0, v);
        chk_val({16'h0, v[15:0] - c0}, 32'd2);
        acc(1'b0, `HTC_OFS_IRQ_STAT, 32'h0, v);
        chk_val(v, 32'h6);
        @(posedge clock) capture_trigger_in <= 1'b0;
        // Standalone: preloads, pin clock, pin reset, raw overflow
        @(posedge clock) standalone_mode <= 1'b1;
        tick(4);
        @(posedge clock) counter_reset_n <= 1'b0;
        tick(6);
        chk_val({16'h0, running_count_value}, 32'h0);
        chk_bit(counter_irq_out, 1'b0);
        @(posedge clock) counter_reset_n <= 1'b1;
        wr(`HTC_OFS_COUNT, 32'h7);
        tick(4);
        chk_val({16'h0, running_count_value}, 32'h0);
        for (i = 1; i <= 4; i++) begin
            @(posedge clock) counter_clock_in <= 1'b1;
            tick(3);
            @(posedge clock) counter_clock_in <= 1'b0;
            tick(3);
            chk_val({16'h0, running_count_value}, i % 4);
            chk_bit(counter_irq_out, i == 4);
        end
        acc(1'b0, `HTC_OFS_IRQ_STAT, 32'h0, v);
        tick(1);
        chk_bit(counter_irq_out, 1'b0);
        report_and_stop();
    end
endmodule : htc_timer_counter_tb_top

bind htc_timer_counter htc_props #(.CW(CW)) i_props (.clock, .srst, .wb_we_i, .wb_stb_i, .wb_cyc_i, .wb_dat_o,
    .wb_ack_o, .counter_reset_n, .counter_irq_out, .wakeup_irq_out, .compare_wave_out, .running_count_value);
